// [logic/dcsr_defs.svh]
`ifndef DCSR_DEFS_SVH
`define DCSR_DEFS_SVH
// register width and reset contents
`define DCSR_WIDTH 4
`define DCSR_RESET_WORD 4'h0
// snapshot fifo shape
`define DCSR_FIFO_DEPTH 16
`define DCSR_FIFO_AW 4
`endif

// [logic/dcsr_pkg.sv]
package dcsr_pkg;
  // action taken on one system clock cycle
  typedef enum logic [1:0] {
    DCSR_HOLD,
    DCSR_LOAD,
    DCSR_SHIFT
  } dcsr_action_t;
endpackage

// [logic/dcsr_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module dcsr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes word
  output logic [WIDTH-1:0] out_data // head word, registered
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic out_valid_reg;
  wire logic do_wr;
  wire logic do_rd;
  wire logic load_out;

  // handshakes; output stage refills when empty or drained
  assign in_ready = (count_reg != (AW+1)'(DEPTH)) && ce;
  assign do_wr = in_valid && in_ready;
  assign load_out = !out_valid_reg || out_ready;
  assign do_rd = ce && load_out && (count_reg != '0);
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  // storage array
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers, count and output register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (ce) begin
      if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      if (load_out) out_valid_reg <= do_rd;
      if (do_rd) out_data_reg <= mem[rd_ptr_reg];
    end
  end
endmodule
`default_nettype wire

// [logic/dcsr_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dcsr_defs.svh"
////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: holds four bits; four parallel, one serial, mode, two clocks.
// R2: mode high, load clock falling edge copies parallel inputs in.
// R3: serial input never enters a stage while mode is high.
// R4: mode low, shift clock falling edge shifts once; load clock ignored.
// R5: shift puts serial in stage zero, stages move up one.
// R6: shift left needs outside wiring of outputs to parallel inputs.
// R7: no selected falling edge means outputs keep their levels.
// R8: both clocks may be tied to one source by the outside.
// R9: outside should change mode only while both clocks are low.
// R10: mode change alone never alters the register contents.
// R11: clocks synchronised to clk_sys; falling edge is one-cycle enable.
module dcsr_top
  import dcsr_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic mode_sel, // high load/left, low right
  input wire logic load_clk, // load/left clock pin
  input wire logic shift_clk, // right shift clock pin
  input wire logic serial_in, // serial data pin
  input wire logic [3:0] par_in, // parallel data pins
  output logic stage0_out, // stage zero
  output logic stage1_out, // stage one
  output logic stage2_out, // stage two
  output logic stage3_out, // stage three
  output logic snap_valid, // snapshot word available
  input wire logic snap_ready, // snapshot consumer ready
  output logic [3:0] snap_data, // word after each update
  output logic snap_overflow_reg // update lost to full fifo
);
  logic [1:0] lclk_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] mode_sync_reg;
  logic serial_sync0_reg;
  logic serial_sync1_reg;
  logic [3:0] par_sync0_reg;
  logic [3:0] par_sync1_reg;
  logic lclk_last_reg;
  logic sclk_last_reg;
  logic [`DCSR_WIDTH-1:0] word_reg;
  logic [`DCSR_WIDTH-1:0] word_next;
  logic snap_push_reg;
  logic fifo_in_ready;
  wire logic lclk_fall;
  wire logic sclk_fall;
  wire logic mode_q;
  dcsr_action_t action;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lclk_sync_reg <= 2'h0;
      sclk_sync_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
      serial_sync0_reg <= 1'b0;
      serial_sync1_reg <= 1'b0;
      par_sync0_reg <= 4'h0;
      par_sync1_reg <= 4'h0;
    end else if (ce) begin
      lclk_sync_reg <= {lclk_sync_reg[0], load_clk};
      sclk_sync_reg <= {sclk_sync_reg[0], shift_clk};
      mode_sync_reg <= {mode_sync_reg[0], mode_sel};
      serial_sync0_reg <= serial_in;
      serial_sync1_reg <= serial_sync0_reg;
      par_sync0_reg <= par_in;
      par_sync1_reg <= par_sync0_reg;
    end
  end

  // R11: edge history taken from second sync stage only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lclk_last_reg <= 1'b0;
      sclk_last_reg <= 1'b0;
    end else if (ce) begin
      lclk_last_reg <= lclk_sync_reg[1];
      sclk_last_reg <= sclk_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // R11: falling edges as one-cycle enables
  assign lclk_fall = lclk_last_reg && !lclk_sync_reg[1];
  assign sclk_fall = sclk_last_reg && !sclk_sync_reg[1];
  assign mode_q = mode_sync_reg[1];

  // R4: mode selects which clock counts
  // R10: mode change alone selects hold
  assign action = (mode_q && lclk_fall) ? DCSR_LOAD :
                  (!mode_q && sclk_fall) ? DCSR_SHIFT : DCSR_HOLD;

  // next word per action
  always_comb begin
    case (action)
      // R2: parallel load; R3: serial unused here
      DCSR_LOAD: word_next = par_sync1_reg;
      // R5: serial into stage zero, others move up
      DCSR_SHIFT: word_next = {word_reg[2:0], serial_sync1_reg};
      // R7: hold contents
      DCSR_HOLD: word_next = word_reg;
      default: word_next = word_reg;
    endcase
  end

  // R1: the four-bit store
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_reg <= `DCSR_RESET_WORD;
      snap_push_reg <= 1'b0;
      snap_overflow_reg <= 1'b0;
    end else if (ce) begin
      word_reg <= word_next;
      snap_push_reg <= (action != DCSR_HOLD);
      if (snap_push_reg && !fifo_in_ready) snap_overflow_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage outputs straight from the store
  assign stage0_out = word_reg[0];
  assign stage1_out = word_reg[1];
  assign stage2_out = word_reg[2];
  assign stage3_out = word_reg[3];

  // snapshot fifo: one entry per load or shift
  dcsr_fifo #(
    .WIDTH(`DCSR_WIDTH),
    .DEPTH(`DCSR_FIFO_DEPTH),
    .AW(`DCSR_FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .in_valid(snap_push_reg),
    .in_ready(fifo_in_ready),
    .in_data(word_reg),
    .out_valid(snap_valid),
    .out_ready(snap_ready),
    .out_data(snap_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // R2: load edge in high mode copies parallel data
  a_load_copy: assert property (@(posedge clk_sys) // R2
    disable iff (rst)
    (ce && mode_q && lclk_fall) |=> word_reg == $past(par_sync1_reg)
  ) else $error("load did not copy parallel data");

  // R3: shift path never taken in high mode
  a_no_serial_load: assert property (@(posedge clk_sys) // R3
    disable iff (rst)
    (ce && mode_q) |-> action != DCSR_SHIFT
  ) else $error("serial entered during load mode");

  // R4: load edge ignored in low mode
  a_load_ignored: assert property (@(posedge clk_sys) // R4
    disable iff (rst)
    (ce && !mode_q && lclk_fall && !sclk_fall) |=> $stable(word_reg)
  ) else $error("load clock acted in shift mode");

  // R5: shift moves data up and takes serial bit
  a_shift_move: assert property (@(posedge clk_sys) // R5
    disable iff (rst)
    (ce && !mode_q && sclk_fall) |=>
      word_reg == {$past(word_reg[2:0]), $past(serial_sync1_reg)}
  ) else $error("shift result wrong");

  // R7: no selected edge holds outputs
  a_hold_outputs: assert property (@(posedge clk_sys) // R7
    disable iff (rst)
    (!(mode_q ? lclk_fall : sclk_fall)) |=> $stable(word_reg)
  ) else $error("outputs changed without edge");

  // R10: mode toggle with clocks idle keeps contents
  a_mode_change: assert property (@(posedge clk_sys) // R10
    disable iff (rst)
    ($changed(mode_q) && !lclk_fall && !sclk_fall) |=> $stable(word_reg)
  ) else $error("mode change altered contents");

  // R11: load edge enable lasts one cycle
  a_edge_pulse: assert property (@(posedge clk_sys) // R11
    disable iff (rst)
    (ce && lclk_fall) |=> !lclk_fall
  ) else $error("edge enable longer than one cycle");

  // R1: each update pushes the new word one cycle on
  a_snap_push: assert property (@(posedge clk_sys) // R1
    disable iff (rst)
    (ce && action != DCSR_HOLD) |=> snap_push_reg
  ) else $error("update not pushed to fifo");

  // R3: shift clock ignored in high mode
  a_shift_blocked: assert property (@(posedge clk_sys) // R3
    disable iff (rst)
    (ce && mode_q && sclk_fall && !lclk_fall) |=> $stable(word_reg)
  ) else $error("shift clock acted in load mode");

  // R7: enable low freezes the store
  a_freeze_hold: assert property (@(posedge clk_sys) // R7
    disable iff (rst)
    !ce |=> $stable(word_reg)
  ) else $error("store changed with enable low");

  // R11: shift edge enable lasts one cycle
  a_sclk_pulse: assert property (@(posedge clk_sys) // R11
    disable iff (rst)
    (ce && sclk_fall) |=> !sclk_fall
  ) else $error("shift enable longer than one cycle");

  // R11: edge history comes from the second sync stage
  a_sync_history: assert property (@(posedge clk_sys) // R11
    disable iff (rst)
    (ce && $past(ce) && lclk_fall) |-> $past(lclk_sync_reg[1])
  ) else $error("load edge not from synced level");

  // R1: a push that finds the fifo full is flagged
  a_overflow_set: assert property (@(posedge clk_sys) // R1
    disable iff (rst)
    (ce && snap_push_reg && !fifo_in_ready) |=> snap_overflow_reg
  ) else $error("lost update not flagged");

  // R1: overflow flag only clears on reset
  a_overflow_sticky: assert property (@(posedge clk_sys) // R1
    disable iff (rst)
    snap_overflow_reg |=> snap_overflow_reg
  ) else $error("overflow flag cleared");
endmodule
`default_nettype wire

// [sim/dcsr_pins.sv]
`timescale 1ns/100ps
`default_nettype none
module dcsr_pins (
  input wire logic left_en, // shift left wiring on
  input wire logic left_bit, // new bit for stage three
  input wire logic [3:0] par_user, // plain parallel word
  input wire logic [3:0] word, // stage levels, bit i = stage i
  output logic [3:0] par_in // parallel pins
);
  // shift left wiring
  // stages one to three fed back to the input below, new bit on the top one
  assign par_in = left_en ? {left_bit, word[3:1]} : par_user;
endmodule
`default_nettype wire

// [sim/tb_dcsr_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_dcsr_top;
  logic clk_sys = 0, rst = 1, ce = 1, mode_sel = 0, serial_in = 0;
  logic load_clk = 0, shift_clk = 0, snap_ready = 0;
  logic left_en = 0, left_bit = 0, snap_valid, snap_overflow_reg;
  logic s0, s1, s2, s3;
  logic [3:0] par_user = 4'h0, par_in, word, snap_data, model;
  logic [3:0] exp_q[$];
  int n_fail = 0, checked = 0, cycles = 0;
  assign word = {s3, s2, s1, s0};
  dcsr_top u_dcsr_top (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .mode_sel(mode_sel), .load_clk(load_clk), .shift_clk(shift_clk),
    .serial_in(serial_in), .par_in(par_in), .stage0_out(s0),
    .stage1_out(s1), .stage2_out(s2), .stage3_out(s3),
    .snap_valid(snap_valid), .snap_ready(snap_ready),
    .snap_data(snap_data), .snap_overflow_reg(snap_overflow_reg));
  dcsr_pins u_dcsr_pins (.left_en(left_en), .left_bit(left_bit),
    .par_user(par_user), .word(word), .par_in(par_in));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end
  task conclude;
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // wait n edges, then drive just after the last one
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // clks[1] load pin, clks[0] shift pin; records the expected snapshot
  task pulse(input logic [1:0] clks, input logic upd);
    load_clk = clks[1];
    shift_clk = clks[0];
    step(3);
    load_clk = 0;
    shift_clk = 0;
    step(6);
    if (upd && exp_q.size() < 17) exp_q.push_back(model);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_load;
    mode_sel = 1;
    serial_in = 1;
    par_user = 4'ha;
    model = 4'ha;
    step(3);
    pulse(2'b10, 1);
    chk(word, model);
  endtask
  task t_shift;
    mode_sel = 0;
    model = {model[2:0], 1'b1};
    step(3);
    pulse(2'b01, 1);
    chk(word, model);
    serial_in = 0;
    model = {model[2:0], 1'b0};
    step(3);
    pulse(2'b01, 1);
    chk(word, model);
  endtask
  task t_refuse;
    pulse(2'b10, 0);
    chk(word, model);
    mode_sel = 1;
    serial_in = 1;
    par_user = 4'h3;
    step(3);
    pulse(2'b01, 0);
    chk(word, model);
    mode_sel = 0;
    step(6);
    mode_sel = 1;
    step(6);
    chk(word, model);
  endtask
  task t_left;
    left_en = 1;
    left_bit = 1;
    model = {1'b1, model[3:1]};
    step(3);
    pulse(2'b10, 1);
    chk(word, model);
    left_en = 0;
  endtask
  task t_both;
    par_user = 4'h6;
    model = 4'h6;
    step(3);
    pulse(2'b11, 1);
    chk(word, model);
    mode_sel = 0;
    serial_in = 0;
    model = 4'hc;
    step(3);
    pulse(2'b11, 1);
    chk(word, model);
  endtask
  task t_fifo;
    mode_sel = 1;
    for (int i = 0; i < 14; i++) begin
      par_user = 4'(i);
      model = 4'(i);
      step(3);
      pulse(2'b10, 1);
    end
    chk({3'h0, snap_overflow_reg}, 4'h1);
    snap_ready = 1;
    // head word looked at while it stands, taken at the next edge
    repeat (30) begin
      if (snap_valid === 1'b1) chk(snap_data, exp_q.pop_front());
      step(1);
    end
    chk(4'(exp_q.size()), 4'h0);
  endtask
  task t_freeze;
    ce = 0;
    pulse(2'b01, 0);
    ce = 1;
    step(3);
    chk(word, model);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    step(8);
    rst = 0;
    step(1);
    chk(word, 4'h0);
    t_load();
    t_shift();
    t_refuse();
    t_left();
    t_both();
    t_freeze();
    t_fifo();
    conclude();
  end
endmodule
`default_nettype wire
